// File: dv/sar_adc_sequencer_bench.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: comparator model on the analog side
// Notes: fast clock setting used where length allows
module sar_adc_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sas_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, timer_pulse_unit = 0, tmr = 0, pin_n = 1, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, comp_out, sample_hold, irq, data_transfer_ctrl;
  wire logic [2:0] ana_chan;
  wire logic [9:0] dac_code;
  int mismatches = 0, comparisons = 0, cyc_n = 0, dtc_n = 0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc_n++;
    if (data_transfer_ctrl === 1'b1) dtc_n++;
  end
  sas_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_pulse_unit_trig(timer_pulse_unit), .eight_bit_timer_trig(tmr), .ext_trigger_pin_n(pin_n), .comp_out(comp_out),
    .ana_chan(ana_chan), .sample_hold(sample_hold), .dac_code(dac_code), .conv_end_irq(irq),
    .data_transfer_ctrl_req(data_transfer_ctrl));
  sas_analog_model u_ana (.ana_chan(ana_chan), .sample_hold(sample_hold), .dac_code(dac_code),
    .comp_out(comp_out));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  function automatic logic [31:0] lvl(input int n);
    return {22'h0, n[2:0], 7'h2b};
  endfunction
  task automatic t_reset;
    rd_chk(sas_off_ctrl_status, 32'h0);
    rd_chk(sas_off_config, 32'h0);
    rd_chk(sas_off_data0, 32'h0);
    rd_chk(12'h100, 32'h0);
    check(32'(err), 32'h1);
    $display("reset test done");
  endtask
  task automatic t_single;
    int n, d;
    for (int c = 0; c < 4; c++) begin
      d = dtc_n;
      apb(1'b1, sas_off_config, 32'(c << 2));
      apb(1'b1, sas_off_ctrl_status, 32'h60 | (c + 1));
      n = 0;
      while (irq !== 1'b1) begin
        @(posedge pclk);
        n++;
      end
      check(32'(n >= sas_first_total[c] + 3 && n <= sas_first_total[c] + sas_delay_mask[c] + 3), 32'h1);
      rd_chk(sas_off_data0 + 12'(4 * (c + 1)), lvl(c + 1));
      rd_chk(sas_off_ctrl_status, 32'hc0 | (c + 1));
      check(32'(dtc_n - d), 32'h1);
      apb(1'b1, sas_off_ctrl_status, 32'hc0 | (c + 1));
      rd_chk(sas_off_ctrl_status, 32'hc0 | (c + 1));
      apb(1'b1, sas_off_ctrl_status, 32'h40 | (c + 1));
      rd_chk(sas_off_ctrl_status, 32'h40 | (c + 1));
      check(32'(irq), 32'h0);
    end
    $display("single test done");
  endtask
  task automatic t_abort;
    apb(1'b1, sas_off_config, 32'h0c);
    apb(1'b1, sas_off_ctrl_status, 32'h27);
    @(negedge sample_hold);
    apb(1'b1, sas_off_ctrl_status, 32'h07);
    repeat (80) @(posedge pclk);
    rd_chk(sas_off_ctrl_status, 32'h07);
    rd_chk(sas_off_data0 + 12'h01c, 32'h0);
    $display("abort test done");
  endtask
  task automatic scan_seq(input logic [31:0] cfg, input logic [31:0] cw, input int first, input int cnt);
    int t_prev;
    apb(1'b1, sas_off_ctrl_status, 32'h0);
    apb(1'b1, sas_off_config, cfg);
    apb(1'b1, sas_off_ctrl_status, cw);
    for (int i = 0; i < 2 * cnt; i++) begin
      @(posedge sample_hold);
      #1;
      check(32'(ana_chan), 32'(first + i % cnt));
      if (i >= 2) check(32'(cyc_n - t_prev), 32'd64);
      t_prev = cyc_n;
      if (i == cnt - 1) rd_chk(sas_off_ctrl_status, cw);
    end
    for (int k = 0; k < cnt; k++) rd_chk(sas_off_data0 + 12'(4 * (first + k)), lvl(first + k));
    rd_chk(sas_off_ctrl_status, cw | 32'h80);
  endtask
  task automatic t_scan;
    scan_seq(32'h2c, 32'h26, 4, 3);
    scan_seq(32'h2c, 32'h21, 0, 2);
    scan_seq(32'h3c, 32'h27, 0, 8);
    apb(1'b1, sas_off_ctrl_status, 32'h0);
    $display("scan test done");
  endtask
  task automatic t_trig;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, sas_off_config, 32'(c << 6) | 32'h0c);
      timer_pulse_unit <= (c == 0 || c == 1);
      tmr <= (c == 0 || c == 2);
      pin_n <= !(c == 0 || c == 3);
      @(posedge pclk);
      timer_pulse_unit <= 1'b0;
      tmr <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, sas_off_ctrl_status, 32'h0);
      check(32'(rd[5]), 32'(c != 0));
      repeat (90) @(posedge pclk);
      rd_chk(sas_off_ctrl_status, c != 0 ? 32'h80 : 32'h0);
      pin_n <= 1'b1;
      apb(1'b1, sas_off_ctrl_status, 32'h0);
    end
    $display("trigger test done");
  endtask
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    $display("Error %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_abort();
    t_scan();
    t_trig();
    end_of_test();
  end
endmodule

// File: dv/sas_analog_model.sv
// Purpose: analog inputs and comparator beside the sequencer
// Assumes: channel n carries level n*128+43
// Notes: level held from the sampling phase on
module sas_analog_model (
  input wire logic [2:0] ana_chan,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  output logic comp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import sas_pkg::*;
  logic [9:0] held = 10'h155;
  always @(*) begin
    if (sample_hold) held = {ana_chan, 7'h2b};
    comp_out = held >= dac_code;
  end
endmodule

// File: dv/sas_sequencer_monitor.sv
// Purpose: port checks of the converter sequencer
// Assumes: zero-wait APB slave
// Notes: bound to every sequencer instance
module sas_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_hold,
  input wire logic [2:0] ana_chan,
  input wire logic [9:0] dac_code,
  input wire logic conv_end_irq,
  input wire logic data_transfer_ctrl_req
);
  import sas_pkg::*;
  // ****************************************
  // checks
  // ****************************************
  logic [9:0] hold_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_len <= 10'h000;
    else hold_len <= sample_hold ? hold_len + 10'h001 : 10'h000;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_answer: assert property (psel && !penable |=> pready) else $error("no ready in access");
  a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not zero");
  a_irq_masked: assert property (psel && penable && pwrite && paddr == sas_off_ctrl_status && !pwdata[6]
    |-> ##2 !conv_end_irq) else $error("irq while disabled");
  a_sample_len: assert property ($fell(sample_hold) && dac_code == 10'h200
    |-> hold_len inside {10'd127, 10'd63, 10'd31, 10'd15})
    else $error("bad sampling length");
  a_chan_hold: assert property (sample_hold && $past(sample_hold) |-> $stable(ana_chan))
    else $error("channel moved while sampling");
  a_xfer_pulse: assert property (data_transfer_ctrl_req |=> !data_transfer_ctrl_req) else $error("long xfer");
  a_xfer_follow: assert property ($rose(conv_end_irq) |-> ##[0:1] data_transfer_ctrl_req)
    else $error("no xfer request");
endmodule

bind sas_sequencer sas_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_hold(sample_hold), .ana_chan(ana_chan), .dac_code(dac_code), .conv_end_irq(conv_end_irq),
  .data_transfer_ctrl_req(data_transfer_ctrl_req));

// File: rtl/sas_pkg.sv
// Purpose: shared constants and types for the converter sequencer
// Assumes: 32-bit APB, one word per register
// Notes: timing counts are in pclk states
package sas_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] sas_off_ctrl_status = 12'h000;
  localparam logic [11:0] sas_off_config = 12'h004;
  localparam logic [11:0] sas_off_data0 = 12'h010;
  localparam logic [11:0] sas_off_data_last = 12'h02c;
  localparam int sas_num_chan = 8;
  localparam int sas_res_bits = 10;
  // ctrl/status fields
  localparam int sas_bit_end_flag = 7;
  localparam int sas_bit_irq_en = 6;
  localparam int sas_bit_start = 5;
  // config fields
  localparam int sas_bit_trig_hi = 7;
  localparam int sas_bit_scan_en = 5;
  localparam int sas_bit_scan_size = 4;
  localparam int sas_bit_clk_hi = 3;
  localparam int sas_bit_clk_lo = 2;
  // trigger select codes
  localparam logic [1:0] sas_trig_off = 2'h0;
  localparam logic [1:0] sas_trig_tpu = 2'h1;
  localparam logic [1:0] sas_trig_tmr = 2'h2;
  localparam logic [1:0] sas_trig_pin = 2'h3;
  // ****************************************
  // timing (states)
  // ****************************************
  localparam logic [9:0] sas_delay_min [4] = '{10'd18, 10'd10, 10'd6, 10'd4};
  localparam logic [9:0] sas_sample [4] = '{10'd127, 10'd63, 10'd31, 10'd15};
  localparam logic [9:0] sas_first_total [4] = '{10'd515, 10'd259, 10'd131, 10'd67};
  localparam logic [9:0] sas_next_total [4] = '{10'd512, 10'd256, 10'd128, 10'd64};
  localparam logic [9:0] sas_delay_mask [4] = '{10'h00f, 10'h007, 10'h003, 10'h001};

  typedef enum logic [1:0] {sas_idle, sas_delay, sas_sampling, sas_convert} sas_state_t;

  typedef struct packed {
    logic [1:0] trig_sel;
    logic scan_enable_bit;
    logic scan_size_bit;
    logic [1:0] conv_clk_sel;
    logic [3:0] chan_sel;
  } sas_cfg_t;
endpackage

// File: rtl/sas_sequencer.sv
// Purpose: sequencing and register logic of a 10-bit SAR converter with eight inputs
// Assumes: analog comparator supplied externally; APB register access
// Notes: zero-wait APB slave, unmapped addresses read zero and signal pslverr
//
// Function
// R01: 10-bit successive approximation, only single and repeating scan modes.
// R02: software clears start before changing mode or channel; may reset together.
// R03: single mode start launches one conversion of the selected channel.
// R04: single mode result goes to that channel's data register.
// R05: end of conversion sets end flag; interrupt only if enabled.
// R06: single mode start reads 1 during conversion, hardware clears at end.
// R07: software clearing start aborts conversion, back to idle.
// R08: scan covers up to four channels (10) or eight channels (11).
// R09: four-channel group starts at 4 if upper bits 01, else 0.
// R10: scan stores each channel result in its own register in turn.
// R11: after whole group: set flag, interrupt if enabled, restart group.
// R12: scan never self-clears start; clear stops, set restarts at first channel.
// R13: start delay, then sampling, then conversion; total includes both.
// R14: start delay depends on write timing, range per clock setting.
// R15: first conversion sampling and total states per clock setting.
// R16: later scan conversions take fixed 512, 256, 128 or 64 states.
// R17: trigger select 11 and falling pin edge sets start bit.
// R18: end interrupt also drives the transfer controller activation output.
// R19: trigger select: off, timer pulse unit, eight-bit timer, pin.
// R20: scan field upper bit 0 selects single mode.
// R21: channel code selects input or last group channel; top bit prohibited.
// R22: end flag accepts only a written 0 which clears it.
// R23: pin synchronised, falling edge gives one-cycle start pulse.
//
// Local design decisions: the APB register port and the register addresses.
module sas_sequencer #(
  parameter int res_bits = sas_pkg::sas_res_bits
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_pulse_unit_trig,
  input wire logic eight_bit_timer_trig,
  input wire logic ext_trigger_pin_n,
  input wire logic comp_out,
  output logic [2:0] ana_chan,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic conv_end_irq,
  output logic data_transfer_ctrl_req
);
  import sas_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  sas_cfg_t cfg;
  logic conv_end_flag;
  logic conv_end_irq_enable;
  logic conv_start_bit;
  logic [res_bits-1:0] result [sas_num_chan];
  sas_state_t state;
  logic [9:0] cnt;
  logic [9:0] phase_cnt;
  logic [3:0] free_cnt;
  logic [2:0] chan;
  logic first_conv;
  logic [res_bits-1:0] sar;
  logic [3:0] bit_idx;
  logic pin_s1, pin_s2, pin_s3;
  logic pin_fall;
  logic done_pulse;
  logic done_last;
  logic group_end;

  wire logic wr = psel && penable && pwrite;
  wire logic rd = psel && !penable && !pwrite;
  wire logic wr_cs = wr && paddr == sas_off_ctrl_status;
  wire logic wr_cfg = wr && paddr == sas_off_config;
  wire logic scan_mode = cfg.scan_enable_bit; // R20
  wire logic [1:0] cks = cfg.conv_clk_sel;
  wire logic conv_done = state == sas_convert && cnt == 10'h000;

  // ****************************************
  // external trigger synchroniser
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
    end else begin
      pin_s1 <= ext_trigger_pin_n;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ****************************************
  // trigger decode
  // ****************************************
  logic trig_hit;
  always_comb begin
    pin_fall = pin_s3 && !pin_s2; // R23
    unique case (cfg.trig_sel) // R19
      sas_trig_off: trig_hit = 1'b0;
      sas_trig_tpu: trig_hit = timer_pulse_unit_trig;
      sas_trig_tmr: trig_hit = eight_bit_timer_trig;
      sas_trig_pin: trig_hit = pin_fall; // R17
    endcase
  end

  // ****************************************
  // group bounds
  // ****************************************
  logic [2:0] first_chan;
  logic [2:0] last_chan;
  always_comb begin
    last_chan = cfg.chan_sel[2:0]; // R21
    if (!scan_mode) begin
      first_chan = cfg.chan_sel[2:0];
    end else if (!cfg.scan_size_bit) begin
      first_chan = cfg.chan_sel[3:2] == 2'h1 ? 3'h4 : 3'h0; // R08 R09
    end else begin
      first_chan = 3'h0; // R09
    end
  end
  assign group_end = chan == last_chan;

  // ****************************************
  // control and status register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start_bit <= 1'b0;
      conv_end_irq_enable <= 1'b0;
    end else begin
      if (wr_cs) begin
        conv_end_irq_enable <= pwdata[sas_bit_irq_en];
      end
      if (trig_hit) begin
        conv_start_bit <= 1'b1; // R17
      end else if (wr_cs) begin
        conv_start_bit <= pwdata[sas_bit_start]; // R07
      end else if (conv_done && !scan_mode) begin
        conv_start_bit <= 1'b0; // R06 R12
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_end_flag <= 1'b0;
    end else if (done_pulse && done_last) begin
      conv_end_flag <= 1'b1; // R05 R11
    end else if (wr_cs && !pwdata[sas_bit_end_flag]) begin
      conv_end_flag <= 1'b0; // R22
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else if (wr_cfg) begin
      cfg.trig_sel <= pwdata[sas_bit_trig_hi -: 2];
      cfg.scan_enable_bit <= pwdata[sas_bit_scan_en];
      cfg.scan_size_bit <= pwdata[sas_bit_scan_size];
      cfg.conv_clk_sel <= pwdata[sas_bit_clk_hi -: 2];
      cfg.chan_sel <= cfg.chan_sel; // channel lives in ctrl/status
    end else if (wr_cs) begin
      cfg.chan_sel <= pwdata[3:0]; // R02
    end
  end

  // ****************************************
  // free-running phase for start delay
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_cnt <= 4'h0;
    end else begin
      free_cnt <= free_cnt + 4'h1; // R14
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  wire logic [9:0] conv_len = first_conv ?
    10'(sas_first_total[cks] - sas_delay_min[cks] - sas_sample[cks]) :
    10'(sas_next_total[cks] - sas_sample[cks]);
  wire logic [9:0] bit_len = 10'(conv_len / 10'(res_bits));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sas_idle;
      cnt <= 10'h000;
      phase_cnt <= 10'h000;
      chan <= 3'h0;
      first_conv <= 1'b1;
      sar <= '0;
      bit_idx <= 4'h0;
      done_pulse <= 1'b0;
      done_last <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      done_last <= 1'b0;
      if (!conv_start_bit) begin
        state <= sas_idle; // R07 R12
        first_conv <= 1'b1;
      end else begin
        unique case (state)
          sas_idle: begin
            state <= sas_delay; // R13
            chan <= first_chan; // R03 R12
            first_conv <= 1'b1;
            cnt <= 10'(sas_delay_min[cks] + (10'(free_cnt) & sas_delay_mask[cks]) - 10'h002); // R14
          end
          sas_delay: begin
            if (cnt == 10'h000) begin
              state <= sas_sampling;
              cnt <= 10'(sas_sample[cks] - 10'h001); // R15
            end else begin
              cnt <= cnt - 10'h001;
            end
          end
          sas_sampling: begin
            if (cnt == 10'h000) begin
              state <= sas_convert; // R13
              sar <= {1'b1, {(res_bits-1){1'b0}}};
              bit_idx <= 4'(res_bits - 1);
              cnt <= 10'(conv_len - 10'h001); // R15 R16
              phase_cnt <= 10'(bit_len - 10'h001);
            end else begin
              cnt <= cnt - 10'h001;
            end
          end
          sas_convert: begin
            if (phase_cnt == 10'h000 && bit_idx != 4'hf) begin
              phase_cnt <= 10'(bit_len - 10'h001);
              if (!comp_out) begin
                sar[bit_idx] <= 1'b0; // R01
              end
              if (bit_idx != 4'h0) begin
                sar[bit_idx - 4'h1] <= 1'b1;
              end
              bit_idx <= bit_idx - 4'h1;
            end else if (phase_cnt != 10'h000) begin
              phase_cnt <= phase_cnt - 10'h001;
            end
            if (cnt == 10'h000) begin
              done_pulse <= 1'b1;
              done_last <= !scan_mode || group_end; // R11
              first_conv <= 1'b0;
              if (scan_mode) begin
                chan <= group_end ? first_chan : chan + 3'h1; // R10 R11
                state <= sas_sampling;
                cnt <= 10'(sas_sample[cks] - 10'h001); // R16
              end else begin
                state <= sas_idle; // R06
              end
            end else begin
              cnt <= cnt - 10'h001;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // result registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < sas_num_chan; i++) begin
        result[i] <= '0;
      end
    end else if (state == sas_convert && cnt == 10'h000 && conv_start_bit) begin
      result[chan] <= sar; // R04 R10
    end
  end

  // ****************************************
  // analog side and interrupt outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_chan <= 3'h0;
      sample_hold <= 1'b0;
      dac_code <= 10'h000;
    end else begin
      ana_chan <= state == sas_idle ? first_chan : chan;
      sample_hold <= state == sas_sampling;
      dac_code <= 10'(sar);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_end_irq <= 1'b0;
      data_transfer_ctrl_req <= 1'b0;
    end else begin
      conv_end_irq <= conv_end_flag && conv_end_irq_enable; // R05
      data_transfer_ctrl_req <= conv_end_flag && conv_end_irq_enable && !conv_end_irq; // R18
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  wire logic data_hit = paddr >= sas_off_data0 && paddr <= sas_off_data_last && paddr[1:0] == 2'h0;
  wire logic [2:0] data_idx = 3'(paddr[4:2] - sas_off_data0[4:2]);
  wire logic mapped = paddr == sas_off_ctrl_status || paddr == sas_off_config || data_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      if (rd) begin
        if (paddr == sas_off_ctrl_status) begin
          prdata <= {24'h0, conv_end_flag, conv_end_irq_enable, conv_start_bit, 1'b0, cfg.chan_sel};
        end else if (paddr == sas_off_config) begin
          prdata <= {24'h0, cfg.trig_sel, cfg.scan_enable_bit, cfg.scan_size_bit, cfg.conv_clk_sel, 2'h0};
        end else if (data_hit) begin
          prdata <= 32'(result[data_idx]);
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end
endmodule
